//--- hw/ascmp_pkg.sv
// shared constants and types of the adc scan select and compare hit block
package ascmp_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam int         ADDR_W    = 8;
  localparam logic [7:0] OFF_SCAN  = 8'h00;
  localparam logic [7:0] OFF_HIT   = 8'h04;
  localparam logic [7:0] OFF_CTRL  = 8'h08;
  localparam logic [7:0] OFF_ISTAT = 8'h0c;
  localparam logic [7:0] OFF_IMASK = 8'h10;
  localparam logic [7:0] OFF_POS   = 8'h14;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int PIN_CNT        = 14;
  localparam int IDX_W          = 5;
  localparam int CM_W           = 2;
  localparam int CTRL_CSCAN_BIT = 0;
  localparam int CTRL_ASCAN_BIT = 1;
  localparam int CTRL_CM_LSB    = 2;
  localparam int CTRL_FIX_LSB   = 4;
  localparam int IRQ_HIT_BIT    = 0;
  localparam int IRQ_WRAP_BIT   = 1;
  localparam int IRQ_W          = 2;

  localparam logic [31:0] SCAN_WMASK_FULL = 32'h7000_3fff;
  localparam logic [31:0] HIT_WMASK_FULL  = 32'h0000_3fff;
  localparam logic [31:0] CTRL_WMASK      = 32'h0000_01ff;
  localparam logic [31:0] PINS_MID_CUT    = 32'h0000_3000;
  localparam logic [31:0] PINS_SMALL_CUT  = 32'h0000_3800;

  // ------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------
  localparam logic [31:0]      SCAN_RST  = 32'h0000_0000;
  localparam logic [31:0]      HIT_RST   = 32'h0000_0000;
  localparam logic [31:0]      CTRL_RST  = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RST   = 2'h0;
  localparam logic [IDX_W-1:0] IDX_RST   = 5'h00;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CM_LESS    = 2'b00,
    CM_GREATER = 2'b01,
    CM_INSIDE  = 2'b10,
    CM_OUTSIDE = 2'b11
  } ascmp_cm_type;

  typedef enum logic [1:0] {
    VAR_FULL  = 2'b00,
    VAR_MID   = 2'b01,
    VAR_SMALL = 2'b11
  } ascmp_variant_type;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } ascmp_seq_type;

  // pins absent in the smaller packages
  function automatic logic [31:0] pin_cut(input ascmp_variant_type v);
    case (v)
      VAR_MID:   pin_cut = PINS_MID_CUT;
      VAR_SMALL: pin_cut = PINS_SMALL_CUT;
      default:   pin_cut = 32'h0000_0000;
    endcase
  endfunction

endpackage

//--- hw/ascmp_scan_seq.sv
// scan sequencer: walks the selected inputs in ascending order
`timescale 1ns/100ps
module ascmp_scan_seq (
  input  logic                          ref_clk,
  input  logic                          nrst,
  input  logic                          run,
  input  logic [31:0]                   sel,
  input  logic                          step,
  output logic [ascmp_pkg::IDX_W-1:0]   cur_idx,
  output logic                          wrap
);

  // ------------------------------------------------------------
  // next selected index after c, cyclic
  // ------------------------------------------------------------
  function automatic logic [ascmp_pkg::IDX_W-1:0] next_after(
    input logic [31:0]                 s,
    input logic [ascmp_pkg::IDX_W-1:0] c
  );
    logic [ascmp_pkg::IDX_W-1:0] p;
    logic                        found;
    next_after = c;
    found      = 1'b0;
    for (int k = 1; k <= 32; k++) begin
      p = c + ascmp_pkg::IDX_W'(k);
      if (!found && s[p]) begin
        next_after = p;
        found      = 1'b1;
      end
    end
  endfunction

  ascmp_pkg::ascmp_seq_type    state_q;
  logic [ascmp_pkg::IDX_W-1:0] nxt;

  assign nxt = next_after(sel, cur_idx);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ascmp_pkg::SEQ_IDLE;
    end else begin
      case (state_q)
        ascmp_pkg::SEQ_IDLE: state_q <= run ? ascmp_pkg::SEQ_RUN : ascmp_pkg::SEQ_IDLE;
        ascmp_pkg::SEQ_RUN:  state_q <= run ? ascmp_pkg::SEQ_RUN : ascmp_pkg::SEQ_IDLE;
        default:             state_q <= ascmp_pkg::SEQ_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // position, unselected inputs skipped
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cur_idx <= ascmp_pkg::IDX_RST;
      wrap    <= 1'b0;
    end else begin
      wrap <= 1'b0;
      if (state_q == ascmp_pkg::SEQ_IDLE && run) begin
        cur_idx <= next_after(sel, 5'h1f);
      end else if (state_q == ascmp_pkg::SEQ_RUN && run && step && (|sel)) begin
        cur_idx <= nxt;
        wrap    <= (nxt <= cur_idx);
      end
    end
  end

endmodule

//--- hw/ascmp_top.sv
// adc scan selection and compare hit registers with apb slave
`timescale 1ns/100ps

// Functional notes
// - Scan select bits 30 to 28 are writable and pick three extra sources for the scan.
// - Scan select bits 13 to 0 are writable, one per analog pin, a one puts it in the scan.
// - The sequencer skips every input whose scan select bit is zero.
// - Scan select bits 31 and 27 to 14 read zero and ignore writes.
// - In outside-window compare mode a hit bit sets when its buffer is written or matches.
// - In every other compare mode a hit bit sets only on a compare match of its channel.
// - Only hit bits 13 to 0 exist, bits 31 to 14 read zero and ignore writes.
// - The smallest package lacks scan select and hit bits 13 to 11.
// - The mid-size package lacks scan select and hit bits 13 and 12.
// - Scan select drives the positive input only while channel scan or auto scan is on.
// - Compare mode 11 is outside, 10 inside, 01 greater than, 00 less than.
module ascmp_top #(
  parameter ascmp_pkg::ascmp_variant_type VARIANT = ascmp_pkg::VAR_FULL,
  parameter int                           RES_W   = 10
) (
  input  logic                          ref_clk,
  input  logic                          nrst,
  input  logic                          psel,
  input  logic                          penable,
  input  logic                          pwrite,
  input  logic [ascmp_pkg::ADDR_W-1:0]  paddr,
  input  logic [31:0]                   pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  logic                          res_valid,
  input  logic [3:0]                    res_ch,
  input  logic [RES_W-1:0]              res_data,
  input  logic [RES_W-1:0]              cmp_lo,
  input  logic [RES_W-1:0]              cmp_hi,
  input  logic                          conv_step,
  output logic [ascmp_pkg::IDX_W-1:0]   pos_input_sel,
  output logic                          scan_active,
  output logic                          irq
);

  localparam logic [31:0] SCAN_MASK = ascmp_pkg::SCAN_WMASK_FULL & ~ascmp_pkg::pin_cut(VARIANT);
  localparam logic [31:0] HIT_MASK  = ascmp_pkg::HIT_WMASK_FULL & ~ascmp_pkg::pin_cut(VARIANT);

  logic [31:0]                   scan_q;
  logic [31:0]                   hit_q;
  logic [31:0]                   ctrl_q;
  logic [ascmp_pkg::IRQ_W-1:0]   istat_q;
  logic [ascmp_pkg::IRQ_W-1:0]   imask_q;
  logic [31:0]                   prdata_q;
  logic [ascmp_pkg::IDX_W-1:0]   pos_q;
  logic [31:0]                   rdata;
  logic [31:0]                   hit_set;
  logic [ascmp_pkg::IRQ_W-1:0]   ev;
  logic [ascmp_pkg::IDX_W-1:0]   cur_idx;
  logic [ascmp_pkg::IDX_W-1:0]   fix_sel;
  ascmp_pkg::ascmp_cm_type       cm;
  logic                          wrap;
  logic                          match;
  logic                          mapped;
  logic                          setup;
  logic                          access;
  logic                          wr;
  logic                          wr_scan;
  logic                          wr_hit;
  logic                          wr_ctrl;
  logic                          wr_istat;
  logic                          wr_imask;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign wr       = access & pwrite;
  assign wr_scan  = wr && (paddr == ascmp_pkg::OFF_SCAN);
  assign wr_hit   = wr && (paddr == ascmp_pkg::OFF_HIT);
  assign wr_ctrl  = wr && (paddr == ascmp_pkg::OFF_CTRL);
  assign wr_istat = wr && (paddr == ascmp_pkg::OFF_ISTAT);
  assign wr_imask = wr && (paddr == ascmp_pkg::OFF_IMASK);
  assign pready   = 1'b1;
  assign pslverr  = access & ~mapped;
  assign prdata   = prdata_q;

  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    case (paddr)
      ascmp_pkg::OFF_SCAN:  rdata = scan_q;
      ascmp_pkg::OFF_HIT:   rdata = hit_q;
      ascmp_pkg::OFF_CTRL:  rdata = ctrl_q;
      ascmp_pkg::OFF_ISTAT: rdata = {30'h0, istat_q};
      ascmp_pkg::OFF_IMASK: rdata = {30'h0, imask_q};
      ascmp_pkg::OFF_POS:   rdata = {27'h0, pos_q};
      default:              mapped = 1'b0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= rdata;
    end
  end

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  assign cm          = ascmp_pkg::ascmp_cm_type'(ctrl_q[ascmp_pkg::CTRL_CM_LSB +: ascmp_pkg::CM_W]);
  assign fix_sel     = ctrl_q[ascmp_pkg::CTRL_FIX_LSB +: ascmp_pkg::IDX_W];
  assign scan_active = ctrl_q[ascmp_pkg::CTRL_CSCAN_BIT] | ctrl_q[ascmp_pkg::CTRL_ASCAN_BIT];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= ascmp_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata & ascmp_pkg::CTRL_WMASK;
    end
  end

  // ------------------------------------------------------------
  // scan selection
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scan_q <= ascmp_pkg::SCAN_RST;
    end else if (wr_scan) begin
      scan_q <= pwdata & SCAN_MASK;
    end
  end

  ascmp_scan_seq u_seq (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .run     (scan_active),
    .sel     (scan_q),
    .step    (conv_step),
    .cur_idx (cur_idx),
    .wrap    (wrap)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pos_q <= ascmp_pkg::IDX_RST;
    end else begin
      pos_q <= scan_active ? cur_idx : fix_sel;
    end
  end

  assign pos_input_sel = pos_q;

  // ------------------------------------------------------------
  // threshold compare
  // ------------------------------------------------------------
  always_comb begin
    case (cm)
      ascmp_pkg::CM_LESS:    match = res_data < cmp_lo;
      ascmp_pkg::CM_GREATER: match = res_data > cmp_lo;
      ascmp_pkg::CM_INSIDE:  match = (res_data >= cmp_lo) && (res_data <= cmp_hi);
      default:               match = (res_data < cmp_lo) || (res_data > cmp_hi);
    endcase
  end

  always_comb begin
    hit_set = 32'h0000_0000;
    if (res_valid && (res_ch < 4'(ascmp_pkg::PIN_CNT))) begin
      // outside mode flags any buffer write, else a match only
      if (cm == ascmp_pkg::CM_OUTSIDE || match) begin
        hit_set[res_ch] = 1'b1;
      end
    end
    hit_set = hit_set & HIT_MASK;
  end

  // ------------------------------------------------------------
  // compare hit flags, set wins over clear
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hit_q <= ascmp_pkg::HIT_RST;
    end else if (wr_hit) begin
      hit_q <= ((hit_q & pwdata) | hit_set) & HIT_MASK;
    end else begin
      hit_q <= hit_q | hit_set;
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  assign ev[ascmp_pkg::IRQ_HIT_BIT]  = |(hit_set & ~hit_q);
  assign ev[ascmp_pkg::IRQ_WRAP_BIT] = wrap;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      istat_q <= ascmp_pkg::IRQ_RST;
    end else if (wr_istat) begin
      istat_q <= (istat_q & ~pwdata[ascmp_pkg::IRQ_W-1:0]) | ev;
    end else begin
      istat_q <= istat_q | ev;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      imask_q <= ascmp_pkg::IRQ_RST;
    end else if (wr_imask) begin
      imask_q <= pwdata[ascmp_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(istat_q & imask_q);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_scan_wr;
    @(posedge ref_clk) disable iff (!nrst)
    wr_scan |=> (scan_q == ($past(pwdata) & SCAN_MASK));
  endproperty
  a_scan_wr: assert property (p_scan_wr)
    else $error("scan select write not stored");

  property p_scan_rsv;
    @(posedge ref_clk) disable iff (!nrst)
    (scan_q & ~ascmp_pkg::SCAN_WMASK_FULL) == 32'h0000_0000;
  endproperty
  a_scan_rsv: assert property (p_scan_rsv)
    else $error("scan select reserved bit set");

  property p_hit_rsv;
    @(posedge ref_clk) disable iff (!nrst)
    (hit_q & ~ascmp_pkg::HIT_WMASK_FULL) == 32'h0000_0000;
  endproperty
  a_hit_rsv: assert property (p_hit_rsv)
    else $error("compare hit reserved bit set");

  property p_small_pins;
    @(posedge ref_clk) disable iff (!nrst)
    (VARIANT == ascmp_pkg::VAR_SMALL) |-> (scan_q[13:11] == 3'h0 && hit_q[13:11] == 3'h0);
  endproperty
  a_small_pins: assert property (p_small_pins)
    else $error("absent pin bit set in small package");

  property p_mid_pins;
    @(posedge ref_clk) disable iff (!nrst)
    (VARIANT == ascmp_pkg::VAR_MID) |-> (scan_q[13:12] == 2'h0 && hit_q[13:12] == 2'h0);
  endproperty
  a_mid_pins: assert property (p_mid_pins)
    else $error("absent pin bit set in mid package");

  property p_hit_outside;
    @(posedge ref_clk) disable iff (!nrst)
    (res_valid && cm == ascmp_pkg::CM_OUTSIDE && res_ch == 4'h0 && HIT_MASK[0])
      |=> hit_q[0];
  endproperty
  a_hit_outside: assert property (p_hit_outside)
    else $error("buffer write did not set hit in outside mode");

  property p_hit_cause;
    @(posedge ref_clk) disable iff (!nrst)
    (|(hit_q & ~$past(hit_q)))
      |-> $past(res_valid && (cm == ascmp_pkg::CM_OUTSIDE || match));
  endproperty
  a_hit_cause: assert property (p_hit_cause)
    else $error("hit bit set without a match");

  property p_hit_hold;
    @(posedge ref_clk) disable iff (!nrst)
    !wr_hit |=> ((hit_q & $past(hit_q)) == $past(hit_q));
  endproperty
  a_hit_hold: assert property (p_hit_hold)
    else $error("hit bit lost without a software clear");

  property p_pos_fixed;
    @(posedge ref_clk) disable iff (!nrst)
    (!scan_active ##1 !scan_active) |-> (pos_q == $past(fix_sel));
  endproperty
  a_pos_fixed: assert property (p_pos_fixed)
    else $error("positive input not from fixed select");

  property p_skip;
    @(posedge ref_clk) disable iff (!nrst)
    (scan_active ##1 (scan_active && conv_step && (|scan_q) && !wr_scan))
      |=> scan_q[cur_idx];
  endproperty
  a_skip: assert property (p_skip)
    else $error("scan stopped on an unselected input");

  property p_inside;
    @(posedge ref_clk) disable iff (!nrst)
    (res_valid && cm == ascmp_pkg::CM_INSIDE && res_ch == 4'h1 && HIT_MASK[1] && !hit_q[1]
      && res_data >= cmp_lo && res_data <= cmp_hi) |=> hit_q[1];
  endproperty
  a_inside: assert property (p_inside)
    else $error("inside window match not flagged");

  property p_ext_src;
    @(posedge ref_clk) disable iff (!nrst)
    wr_scan |=> (scan_q[30:28] == $past(pwdata[30:28]));
  endproperty
  a_ext_src: assert property (p_ext_src)
    else $error("extra source select bits not stored");

  property p_hit_clear;
    @(posedge ref_clk) disable iff (!nrst)
    (wr_hit && hit_set == 32'h0000_0000) |=> (hit_q == $past(hit_q & pwdata));
  endproperty
  a_hit_clear: assert property (p_hit_clear)
    else $error("hit bits not cleared by a zero write");

endmodule

//--- tb/ascmp_top_test.sv
// self-checking bench of the adc scan select and compare hit block
`timescale 1ns/100ps
module ascmp_top_test;
  localparam int RES_W = 10;

  logic                         ref_clk   = 1'b0;
  logic                         nrst      = 1'b0;
  logic                         psel      = 1'b0;
  logic                         penable   = 1'b0;
  logic                         pwrite    = 1'b0;
  logic [ascmp_pkg::ADDR_W-1:0] paddr     = 8'h00;
  logic [31:0]                  pwdata    = 32'h0000_0000;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         res_valid = 1'b0;
  logic [3:0]                   res_ch    = 4'h0;
  logic [RES_W-1:0]             res_data  = '0;
  logic [RES_W-1:0]             cmp_lo    = '0;
  logic [RES_W-1:0]             cmp_hi    = '0;
  logic                         conv_step = 1'b0;
  logic [ascmp_pkg::IDX_W-1:0]  pos_input_sel;
  logic                         scan_active;
  logic                         irq;
  int                           mismatches = 0;
  int                           num_checks = 0;
  logic [31:0]                  seed       = 32'h3655;
  logic [31:0]                  rd;
  logic                         err;
  logic [31:0]                  hit_exp;

  always #5 ref_clk = ~ref_clk;

  ascmp_top #(
    .VARIANT (ascmp_pkg::VAR_FULL),
    .RES_W   (RES_W)
  ) u_ascmp_top (
    .ref_clk       (ref_clk),
    .nrst          (nrst),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .res_valid     (res_valid),
    .res_ch        (res_ch),
    .res_data      (res_data),
    .cmp_lo        (cmp_lo),
    .cmp_hi        (cmp_hi),
    .conv_step     (conv_step),
    .pos_input_sel (pos_input_sel),
    .scan_active   (scan_active),
    .irq           (irq)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction

  function automatic logic hit_match(input logic [1:0] cm, input logic [RES_W-1:0] v,
                                     input logic [RES_W-1:0] lo, input logic [RES_W-1:0] hi);
    case (cm)
      2'b00:   hit_match = v < lo;
      2'b01:   hit_match = v > lo;
      2'b10:   hit_match = (v >= lo) && (v <= hi);
      default: hit_match = (v < lo) || (v > hi);
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, pready, 1'b1);
      give_verdict();
    end else begin
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic send_res(input logic [3:0] ch, input logic [RES_W-1:0] v,
                          input logic [RES_W-1:0] lo, input logic [RES_W-1:0] hi);
    @(posedge ref_clk);
    res_valid <= 1'b1;
    res_ch    <= ch;
    res_data  <= v;
    cmp_lo    <= lo;
    cmp_hi    <= hi;
    @(posedge ref_clk);
    res_valid <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic scan_step();
    @(posedge ref_clk);
    conv_step <= 1'b1;
    @(posedge ref_clk);
    conv_step <= 1'b0;
    settle();
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [1:0]       cm;
    logic [3:0]       ch;
    logic [RES_W-1:0] v;
    logic [RES_W-1:0] lo;
    logic [RES_W-1:0] hi;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    check({25'h0, irq, scan_active, pos_input_sel}, 32'h0);
    rd_chk(ascmp_pkg::OFF_SCAN, 32'h0);
    rd_chk(ascmp_pkg::OFF_HIT, 32'h0);
    $display("test reset done");

    apb(1'b1, ascmp_pkg::OFF_SCAN, 32'hffff_ffff);
    rd_chk(ascmp_pkg::OFF_SCAN, 32'h7000_3fff);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      apb(1'b1, ascmp_pkg::OFF_SCAN, seed);
      rd_chk(ascmp_pkg::OFF_SCAN, seed & 32'h7000_3fff);
    end
    apb(1'b1, ascmp_pkg::OFF_HIT, 32'hffff_ffff);
    rd_chk(ascmp_pkg::OFF_HIT, 32'h0);
    check({31'h0, err}, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(1'b1, 8'h18, 32'h5555_aaaa);
    check({31'h0, err}, 32'h1);
    $display("test registers done");

    for (int m = 0; m < 4; m++) begin
      cm = 2'(m);
      apb(1'b1, ascmp_pkg::OFF_CTRL, {28'h0, cm, 2'b00});
      apb(1'b1, ascmp_pkg::OFF_HIT, 32'h0);
      hit_exp = 32'h0;
      for (int k = 0; k < 10; k++) begin
        seed = lfsr(seed);
        // first result lands in the window on channel 1 (inside) or 0 (outside)
        ch   = (k == 0) ? 4'(3 - m) : 4'(seed[7:0] % 14);
        lo   = seed[17:8];
        hi   = (k == 0) ? 10'h3ff : RES_W'(lo + {1'b0, seed[26:18]});
        v    = (k == 0) ? lo : seed[31:22];
        send_res(ch, v, lo, hi);
        if (cm == 2'b11 || hit_match(cm, v, lo, hi)) begin
          hit_exp[ch] = 1'b1;
        end
      end
      // channel 14 does not exist and must be ignored
      send_res(4'he, 10'h000, 10'h3ff, 10'h3ff);
      rd_chk(ascmp_pkg::OFF_HIT, hit_exp);
    end
    $display("test compare done");

    apb(1'b1, ascmp_pkg::OFF_IMASK, 32'h0);
    @(negedge ref_clk);
    check({31'h0, irq}, 32'h0);
    rd_chk(ascmp_pkg::OFF_ISTAT, 32'h1);
    apb(1'b1, ascmp_pkg::OFF_IMASK, 32'h1);
    @(negedge ref_clk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, ascmp_pkg::OFF_ISTAT, 32'h1);
    @(negedge ref_clk);
    check({31'h0, irq}, 32'h0);
    hit_exp = hit_exp & (hit_exp - 32'h1);
    apb(1'b1, ascmp_pkg::OFF_HIT, hit_exp);
    rd_chk(ascmp_pkg::OFF_HIT, hit_exp);
    $display("test interrupt done");

    apb(1'b1, ascmp_pkg::OFF_SCAN, 32'h2000_0024);
    apb(1'b1, ascmp_pkg::OFF_CTRL, 32'h0000_00a0);
    settle();
    check({26'h0, scan_active, pos_input_sel}, 32'h0000_000a);
    apb(1'b1, ascmp_pkg::OFF_CTRL, 32'h0000_00a1);
    settle();
    check({26'h0, scan_active, pos_input_sel}, 32'h0000_0022);
    scan_step();
    check({27'h0, pos_input_sel}, 32'h0000_0005);
    scan_step();
    check({27'h0, pos_input_sel}, 32'h0000_001d);
    scan_step();
    check({27'h0, pos_input_sel}, 32'h0000_0002);
    rd_chk(ascmp_pkg::OFF_ISTAT, 32'h2);
    rd_chk(ascmp_pkg::OFF_POS, 32'h2);
    apb(1'b1, ascmp_pkg::OFF_CTRL, 32'h0000_00a2);
    settle();
    check({26'h0, scan_active, pos_input_sel}, 32'h0000_0022);
    $display("test scan done");
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    check({25'h0, irq, scan_active, pos_input_sel}, 32'h0);
    rd_chk(ascmp_pkg::OFF_SCAN, 32'h0);
    rd_chk(ascmp_pkg::OFF_HIT, 32'h0);
    $display("test second reset done");
    give_verdict();
  end
endmodule
